/* core/edsm_cfg.svh */
`ifndef EDSM_CFG_SVH
`define EDSM_CFG_SVH
`define EDSM_WIN_BIT 15
`define EDSM_PSV_BIT 9
`define EDSM_HALF_BIT 8
`define EDSM_RPAG_RST 10'h001
`define EDSM_WPAG_RST 9'h001
`define EDSM_RD_CYC 2'h2
`define EDSM_RPT_CYC 2'h3
`define EDSM_RPT_SLOW 2'h2
`define EDSM_FAST_CYC 2'h1
`define EDSM_WORD_STEP 15'h0002
`endif

/* core/edsm_pkg.sv */
package edsm_pkg;
  typedef struct packed {
    logic valid;
    logic write;
    logic dword;
    logic rmw;
    logic in_repeat;
    logic [15:0] eff_addr;
    logic [31:0] wdata;
  } edsm_req_s;
  typedef struct packed {
    logic valid;
    logic write;
    logic prog;
    logic prog_upper;
    logic [23:0] addr;
    logic [15:0] wdata;
  } edsm_mem_s;
  typedef enum logic [2:0] {
    EDSM_IDLE = 3'b001,
    EDSM_WAIT = 3'b010,
    EDSM_HI = 3'b100
  } edsm_state_e;
endpackage : edsm_pkg

/* core/edsm_mapper.sv */
`timescale 1ns/1ps
`default_nettype none
`include "edsm_cfg.svh"
module edsm_mapper (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // page register loads from the cpu
  input wire logic rpag_we,
  input wire logic [9:0] rpag_wdata,
  input wire logic wpag_we,
  input wire logic [8:0] wpag_wdata,
  output logic [9:0] read_page_select,
  output logic [8:0] write_page_select,
  // cpu request side
  input wire edsm_pkg::edsm_req_s req,
  output logic req_ready,
  output logic addr_error_trap,
  output logic rd_done,
  output logic [31:0] rdata,
  // memory side
  output edsm_pkg::edsm_mem_s mem,
  input wire logic [15:0] mem_rdata
);
  // ---------------------------------------------------------------
  // translation
  // ---------------------------------------------------------------
  function automatic logic [23:0] map_addr(input logic [15:0] ea, input logic wr,
                                           input logic [9:0] rp, input logic [8:0] wp);
    logic [8:0] pg;
    pg = wr ? wp : rp[8:0];
    if (!ea[`EDSM_WIN_BIT]) map_addr = {8'h00, ea};
    else if (!wr && rp[`EDSM_PSV_BIT]) map_addr = {1'b0, rp[7:0], ea[14:0]};
    else map_addr = {pg, ea[14:0]};
  endfunction : map_addr

  function automatic logic page_zero(input logic [15:0] ea, input logic wr,
                                     input logic [9:0] rp, input logic [8:0] wp);
    page_zero = ea[`EDSM_WIN_BIT] && (wr ? (wp == 9'h000) : (rp == 10'h000));
  endfunction : page_zero

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [9:0] rpag_q, rpag_d;
  logic [8:0] wpag_q, wpag_d;
  // pages frozen at take, so a page load in mid-transfer cannot split a double word
  logic [9:0] rp_q, rp_d;
  logic [8:0] wp_q, wp_d;
  edsm_pkg::edsm_state_e st_q, st_d;
  logic [1:0] cnt_q, cnt_d;
  logic [1:0] rpt_q, rpt_d;
  logic [15:0] ea_q, ea_d;
  logic wr_q, wr_d, dw_q, dw_d, win_q, win_d, rep_q, rep_d;
  logic [15:0] whi_q, whi_d, wlo_q, wlo_d;
  logic [31:0] rdata_q, rdata_d;
  logic done_q, done_d, trap_q, trap_d;
  logic [15:0] cur_ea;
  logic [1:0] rd_need;

  assign read_page_select = rpag_q;
  assign write_page_select = wpag_q;
  assign req_ready = (st_q == edsm_pkg::EDSM_IDLE);
  assign rdata = rdata_q;
  assign rd_done = done_q;
  assign addr_error_trap = trap_q;
  // second word of a double goes to the adjacent word, same page
  assign cur_ea = (st_q == edsm_pkg::EDSM_HI) ? {ea_q[15], ea_q[14:0] + `EDSM_WORD_STEP} : ea_q;

  always_comb begin
    mem.valid = 1'b0;
    mem.write = 1'b0;
    mem.prog = 1'b0;
    mem.prog_upper = 1'b0;
    mem.addr = map_addr(cur_ea, wr_q, rp_q, wp_q);
    mem.wdata = (st_q == edsm_pkg::EDSM_HI) ? whi_q : wlo_q;
    if (st_q != edsm_pkg::EDSM_IDLE) begin
      mem.valid = 1'b1;
      mem.write = wr_q;
      mem.prog = !wr_q && cur_ea[15] && rp_q[`EDSM_PSV_BIT];
      mem.prog_upper = mem.prog && rp_q[`EDSM_HALF_BIT];
    end
  end

  // repeat loop: first two window reads slow, the rest single cycle
  always_comb begin
    if (!win_q) rd_need = `EDSM_FAST_CYC;
    else if (rep_q) rd_need = (rpt_q < `EDSM_RPT_SLOW) ? `EDSM_RPT_CYC : `EDSM_FAST_CYC;
    else rd_need = `EDSM_RD_CYC;
  end

  always_comb begin
    rpag_d = rpag_q;
    wpag_d = wpag_q;
    st_d = st_q;
    cnt_d = cnt_q;
    rpt_d = rpt_q;
    ea_d = ea_q;
    wr_d = wr_q;
    dw_d = dw_q;
    win_d = win_q;
    rep_d = rep_q;
    whi_d = whi_q;
    wlo_d = wlo_q;
    rp_d = rp_q;
    wp_d = wp_q;
    rdata_d = rdata_q;
    done_d = 1'b0;
    trap_d = 1'b0;
    // only explicit loads move the pages, never address wrap
    if (rpag_we) rpag_d = rpag_wdata;
    if (wpag_we) wpag_d = wpag_wdata;
    if (!req.in_repeat) rpt_d = 2'h0;
    case (st_q)
      edsm_pkg::EDSM_IDLE: begin
        if (req.valid) begin
          if (page_zero(req.eff_addr, req.write && !req.rmw, rpag_q, wpag_q)) begin
            trap_d = 1'b1;
          end else begin
            ea_d = req.eff_addr;
            // read-modify-write resolves through the read page
            wr_d = req.write && !req.rmw;
            dw_d = req.dword;
            win_d = req.eff_addr[15];
            rep_d = req.in_repeat;
            whi_d = req.wdata[31:16];
            wlo_d = req.wdata[15:0];
            rp_d = rpag_q;
            wp_d = wpag_q;
            cnt_d = 2'h1;
            st_d = edsm_pkg::EDSM_WAIT;
          end
        end
      end
      edsm_pkg::EDSM_WAIT, edsm_pkg::EDSM_HI: begin
        if (wr_q || cnt_q >= rd_need) begin
          if (!wr_q) begin
            if (st_q == edsm_pkg::EDSM_HI) rdata_d[31:16] = mem_rdata;
            else rdata_d = {16'h0000, mem_rdata};
            if (rep_q && win_q && rpt_q < `EDSM_RPT_SLOW) rpt_d = rpt_q + 2'h1;
          end
          cnt_d = 2'h1;
          if (dw_q && st_q == edsm_pkg::EDSM_WAIT) begin
            st_d = edsm_pkg::EDSM_HI;
          end else begin
            st_d = edsm_pkg::EDSM_IDLE;
            done_d = !wr_q;
          end
        end else begin
          cnt_d = cnt_q + 2'h1;
        end
      end
      default: st_d = edsm_pkg::EDSM_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rpag_q <= `EDSM_RPAG_RST;
      wpag_q <= `EDSM_WPAG_RST;
      st_q <= edsm_pkg::EDSM_IDLE;
      cnt_q <= 2'h0;
      rpt_q <= 2'h0;
      ea_q <= 16'h0000;
      wr_q <= 1'b0;
      dw_q <= 1'b0;
      win_q <= 1'b0;
      rep_q <= 1'b0;
      whi_q <= 16'h0000;
      wlo_q <= 16'h0000;
      rp_q <= `EDSM_RPAG_RST;
      wp_q <= `EDSM_WPAG_RST;
      rdata_q <= 32'h0000_0000;
      done_q <= 1'b0;
      trap_q <= 1'b0;
    end else if (clk_en) begin
      rpag_q <= rpag_d;
      wpag_q <= wpag_d;
      st_q <= st_d;
      cnt_q <= cnt_d;
      rpt_q <= rpt_d;
      ea_q <= ea_d;
      wr_q <= wr_d;
      dw_q <= dw_d;
      win_q <= win_d;
      rep_q <= rep_d;
      whi_q <= whi_d;
      wlo_q <= wlo_d;
      rp_q <= rp_d;
      wp_q <= wp_d;
      rdata_q <= rdata_d;
      done_q <= done_d;
      trap_q <= trap_d;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_trap_zero;
    @(posedge core_clk) disable iff (!rst_n)
    (clk_en && req_ready && req.valid && req.eff_addr[15] && !req.write && rpag_q == 10'h000)
      |=> addr_error_trap && req_ready && !mem.valid;
  endproperty
  a_trap_zero: assert property (p_trap_zero) else $error("page zero read not trapped");

  property p_trap_wr;
    @(posedge core_clk) disable iff (!rst_n)
    (clk_en && req_ready && req.valid && req.eff_addr[15] && req.write && !req.rmw
      && wpag_q == 9'h000) |=> addr_error_trap && !mem.valid;
  endproperty
  a_trap_wr: assert property (p_trap_wr) else $error("page zero write not trapped");

  property p_low_direct;
    @(posedge core_clk) disable iff (!rst_n)
    (mem.valid && !cur_ea[15]) |-> mem.addr == {8'h00, cur_ea};
  endproperty
  a_low_direct: assert property (p_low_direct) else $error("low address altered");

  property p_wr_map;
    @(posedge core_clk) disable iff (!rst_n)
    (mem.valid && mem.write && cur_ea[15]) |-> mem.addr == {wp_q, cur_ea[14:0]};
  endproperty
  a_wr_map: assert property (p_wr_map) else $error("write address wrong");

  property p_rd_map;
    @(posedge core_clk) disable iff (!rst_n)
    (mem.valid && !mem.write && cur_ea[15] && !rp_q[9])
      |-> mem.addr == {rp_q[8:0], cur_ea[14:0]};
  endproperty
  a_rd_map: assert property (p_rd_map) else $error("read address wrong");

  property p_prog_map;
    @(posedge core_clk) disable iff (!rst_n)
    (mem.valid && !mem.write && cur_ea[15] && rp_q[9])
      |-> mem.prog && mem.addr[22:0] == {rp_q[7:0], cur_ea[14:0]} && mem.prog_upper == rp_q[8];
  endproperty
  a_prog_map: assert property (p_prog_map) else $error("program window wrong");

  sequence s_win_read;
    clk_en && req_ready && req.valid && !req.write && !req.dword && !req.in_repeat
      && req.eff_addr[15] && rpag_q != 10'h000;
  endsequence
  property p_rd_cycles;
    @(posedge core_clk) disable iff (!rst_n)
    s_win_read ##1 clk_en[*2] |-> !req_ready ##1 req_ready;
  endproperty
  a_rd_cycles: assert property (p_rd_cycles) else $error("window read not two cycles");

  sequence s_rpt_slow;
    clk_en && req_ready && req.valid && !req.write && !req.dword && req.in_repeat
      && req.eff_addr[15] && rpag_q != 10'h000 && rpt_q < `EDSM_RPT_SLOW;
  endsequence
  property p_rpt_slow;
    @(posedge core_clk) disable iff (!rst_n)
    s_rpt_slow ##1 clk_en[*3] |-> !req_ready ##1 req_ready;
  endproperty
  a_rpt_slow: assert property (p_rpt_slow) else $error("early repeat read not three cycles");

  sequence s_rpt_fast;
    clk_en && req_ready && req.valid && !req.write && !req.dword && req.in_repeat
      && req.eff_addr[15] && rpag_q != 10'h000 && rpt_q == `EDSM_RPT_SLOW;
  endsequence
  property p_rpt_fast;
    @(posedge core_clk) disable iff (!rst_n)
    s_rpt_fast ##1 clk_en |-> !req_ready ##1 req_ready;
  endproperty
  a_rpt_fast: assert property (p_rpt_fast) else $error("later repeat read not one cycle");

  property p_wr_single;
    @(posedge core_clk) disable iff (!rst_n)
    (clk_en && req_ready && req.valid && req.write && !req.rmw && !req.dword
      && wpag_q != 9'h000) ##1 clk_en |=> req_ready;
  endproperty
  a_wr_single: assert property (p_wr_single) else $error("write not single cycle");

  property p_rmw_read;
    @(posedge core_clk) disable iff (!rst_n)
    (clk_en && req_ready && req.valid && req.rmw && req.eff_addr[15] && rpag_q != 10'h000)
      |=> mem.valid && !mem.write;
  endproperty
  a_rmw_read: assert property (p_rmw_read) else $error("rmw not resolved as read");

  property p_page_hold;
    @(posedge core_clk) disable iff (!rst_n)
    (clk_en && !rpag_we && !wpag_we) |=> $stable(rpag_q) && $stable(wpag_q);
  endproperty
  a_page_hold: assert property (p_page_hold) else $error("page changed by itself");

  property p_dw_page;
    @(posedge core_clk) disable iff (!rst_n)
    (st_q == edsm_pkg::EDSM_HI) |-> mem.addr[14:0] == ea_q[14:0] + `EDSM_WORD_STEP || !ea_q[15];
  endproperty
  a_dw_page: assert property (p_dw_page) else $error("second word misplaced");

  property p_dw_same_page;
    @(posedge core_clk) disable iff (!rst_n)
    (st_q == edsm_pkg::EDSM_HI) |-> mem.addr[23:15] == $past(mem.addr[23:15]);
  endproperty
  a_dw_same_page: assert property (p_dw_same_page) else $error("second word changed page");
endmodule : edsm_mapper
`default_nettype wire

/* testbench/edsm_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// combinational memory behind the mapper
// ----------------------------------------
module edsm_mem_model (
  // clock
  input wire logic core_clk,
  // memory side of the mapper
  input wire edsm_pkg::edsm_mem_s mem,
  output logic [15:0] mem_rdata
);
  logic [15:0] last_q;
  logic [15:0] fresh;
  // data tied to address and window kind, so a wrong mapping shows in rdata
  assign fresh = mem.addr[15:0] ^ {mem.addr[23:16], 8'h3C} ^ {mem.prog, mem.prog_upper, 14'h0000};
  // idle bus shows the inverse of the last word, never a stale match
  assign mem_rdata = mem.valid ? fresh : ~last_q;
  always_ff @(posedge core_clk) begin
    if (mem.valid) begin
      last_q <= fresh;
    end
  end
endmodule : edsm_mem_model
`default_nettype wire

/* testbench/edsm_mapper_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module edsm_mapper_tb_top;
  logic core_clk, rst_n, clk_en, rpag_we, wpag_we, req_ready, addr_error_trap, rd_done;
  logic trap_s, done_s, prog_s, up_s, wr_s;
  logic [9:0] rpag_wdata, read_page_select;
  logic [8:0] wpag_wdata, write_page_select;
  logic [31:0] rdata;
  logic [15:0] mem_rdata, w_lo, w_hi;
  logic [23:0] a_lo, a_hi;
  edsm_pkg::edsm_req_s req;
  edsm_pkg::edsm_mem_s mem;
  int err_count, samples_checked, n_mem;

  edsm_mapper i_edsm_mapper (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
    .rpag_we(rpag_we), .rpag_wdata(rpag_wdata), .wpag_we(wpag_we), .wpag_wdata(wpag_wdata),
    .read_page_select(read_page_select), .write_page_select(write_page_select),
    .req(req), .req_ready(req_ready), .addr_error_trap(addr_error_trap),
    .rd_done(rd_done), .rdata(rdata), .mem(mem), .mem_rdata(mem_rdata));
  edsm_mem_model i_edsm_mem_model (.core_clk(core_clk), .mem(mem), .mem_rdata(mem_rdata));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  function automatic logic [15:0] fdat(input logic [23:0] a, input logic p, input logic u);
    return a[15:0] ^ {a[23:16], 8'h3C} ^ {p, u, 14'h0000};
  endfunction : fdat

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic set_pages(input logic [9:0] r, input logic [8:0] w);
    @(negedge core_clk);
    rpag_we = 1'b1;
    wpag_we = 1'b1;
    rpag_wdata = r;
    wpag_wdata = w;
    @(negedge core_clk);
    rpag_we = 1'b0;
    wpag_we = 1'b0;
  endtask : set_pages

  // one request, then six cycles of watching the memory side and pulses
  task automatic xfer(input logic wr, dw, rmw, rpt, input logic [15:0] ea,
                      input logic [31:0] wd);
    @(negedge core_clk);
    req = '{1'b1, wr, dw, rmw, rpt, ea, wd};
    @(posedge core_clk);
    n_mem = 0;
    {trap_s, done_s, prog_s, up_s, wr_s} = 5'h00;
    repeat (6) begin
      @(negedge core_clk);
      req.valid = 1'b0;
      if (mem.valid === 1'b1) begin
        if (n_mem == 0) begin
          a_lo = mem.addr;
          w_lo = mem.wdata;
        end
        a_hi = mem.addr;
        w_hi = mem.wdata;
        {prog_s, up_s, wr_s} = {mem.prog, mem.prog_upper, mem.write};
        n_mem++;
      end
      trap_s = trap_s | addr_error_trap;
      done_s = done_s | rd_done;
    end
  endtask : xfer

  // pulse reset in mid-run when asked, then check page selects, req_ready, trap, done, mem.valid and rdata at reset values
  task automatic t_reset(input logic pulse);
    if (pulse) begin
      @(negedge core_clk);
      rst_n = 1'b0;
      repeat (2) @(negedge core_clk);
      rst_n = 1'b1;
    end
    cmp(read_page_select, 10'h001);
    cmp(write_page_select, 9'h001);
    cmp({req_ready, addr_error_trap, rd_done, mem.valid}, 4'h8);
    cmp(rdata, 32'h0000_0000);
  endtask : t_reset

  // clock enable low in mid-read: nothing moves, the read stretches by the frozen cycles
  task automatic t_freeze;
    n_mem = 0;
    done_s = 1'b0;
    @(negedge core_clk);
    req = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 16'h8400, 32'h0000_0000};
    @(negedge core_clk);
    req.valid = 1'b0;
    clk_en = 1'b0;
    a_lo = mem.addr;
    for (int i = 0; i < 8; i++) begin
      if (i == 3) clk_en = 1'b1;
      n_mem += (mem.valid === 1'b1) ? 1 : 0;
      done_s = done_s | rd_done;
      @(negedge core_clk);
    end
    cmp({done_s, a_lo, 8'(n_mem)}, {1'b1, 24'h008400, 8'h05});
    cmp(rdata[15:0], fdat(24'h008400, 1'b0, 1'b0));
  endtask : t_freeze

  task automatic t_low_and_trap;
    set_pages(10'h000, 9'h000);
    xfer(1'b0, 1'b0, 1'b0, 1'b0, 16'h7FFE, 32'h0000_0000);
    cmp({trap_s, a_lo}, {1'b0, 24'h007FFE});
    cmp(rdata[15:0], fdat(24'h007FFE, 1'b0, 1'b0));
    xfer(1'b0, 1'b0, 1'b0, 1'b0, 16'h8000, 32'h0000_0000);
    cmp({trap_s, done_s, 8'(n_mem)}, {2'b10, 8'h00});
    xfer(1'b1, 1'b0, 1'b0, 1'b0, 16'h9000, 32'h0000_0000);
    cmp({trap_s, 8'(n_mem)}, {1'b1, 8'h00});
    set_pages(10'h000, 9'h001);
    xfer(1'b1, 1'b0, 1'b0, 1'b0, 16'hFFFE, 32'h0000_00A5);
    cmp({trap_s, a_lo}, {1'b0, 24'h00FFFE});
  endtask : t_low_and_trap

  task automatic t_window;
    set_pages(10'h002, 9'h1FF);
    cmp(write_page_select, 9'h1FF);
    xfer(1'b0, 1'b0, 1'b0, 1'b0, 16'h8800, 32'h0000_0000);
    cmp(a_lo, 24'h010800);
    cmp({done_s, 8'(n_mem)}, {1'b1, 8'h02});
    cmp(rdata[15:0], fdat(24'h010800, 1'b0, 1'b0));
    xfer(1'b1, 1'b0, 1'b1, 1'b0, 16'h8802, 32'h0000_0000);
    cmp({wr_s, done_s, a_lo}, {1'b0, 1'b1, 24'h010802});
    xfer(1'b1, 1'b0, 1'b0, 1'b0, 16'hFFFE, 32'h0000_1234);
    cmp({wr_s, a_lo, w_lo}, {1'b1, 24'hFFFFFE, 16'h1234});
    cmp(n_mem, 1);
  endtask : t_window

  task automatic t_dword;
    set_pages(10'h002, 9'h003);
    xfer(1'b0, 1'b1, 1'b0, 1'b0, 16'hFFFE, 32'h0000_0000);
    cmp({a_lo, a_hi}, {24'h017FFE, 24'h010000});
    cmp(rdata, {fdat(24'h010000, 1'b0, 1'b0), fdat(24'h017FFE, 1'b0, 1'b0)});
    cmp(read_page_select, 10'h002);
    xfer(1'b1, 1'b1, 1'b0, 1'b0, 16'h8000, 32'h4455_1122);
    cmp({a_lo, w_lo, a_hi, w_hi}, {24'h018000, 16'h1122, 24'h018002, 16'h4455});
    cmp(n_mem, 2);
  endtask : t_dword

  task automatic t_prog;
    for (int i = 0; i < 2; i++) begin
      set_pages({1'b1, i[0], 8'hA5}, 9'h001);
      xfer(1'b0, 1'b0, 1'b0, 1'b0, 16'hC123, 32'h0000_0000);
      cmp({prog_s, up_s}, {1'b1, i[0]});
      cmp(a_lo, {1'b0, 8'hA5, 15'h4123});
      cmp(rdata[15:0], fdat({1'b0, 8'hA5, 15'h4123}, 1'b1, i[0]));
    end
  endtask : t_prog

  task automatic t_repeat;
    set_pages(10'h002, 9'h002);
    for (int k = 0; k < 4; k++) begin
      xfer(1'b0, 1'b0, 1'b0, 1'b1, 16'h8000 + 16'(2 * k), 32'h0000_0000);
      cmp(n_mem, (k < 2) ? 3 : 1);
    end
    xfer(1'b0, 1'b0, 1'b0, 1'b0, 16'h8010, 32'h0000_0000);
    cmp(n_mem, 2);
  endtask : t_repeat

  task automatic print_verdict;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict

  // watchdog: the whole sequence needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    print_verdict();
  end

  initial begin
    {rst_n, rpag_we, wpag_we, rpag_wdata, wpag_wdata} = '0;
    clk_en = 1'b1;
    req = '0;
    err_count = 0;
    samples_checked = 0;
    repeat (20) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1'b1;
    t_reset(1'b0);
    t_low_and_trap();
    t_window();
    t_dword();
    t_prog();
    t_repeat();
    t_reset(1'b1);
    t_freeze();
    print_verdict();
  end
endmodule : edsm_mapper_tb_top
`default_nettype wire
